// >>> testbench/bprc_ctrl_tb.sv
// Self-checking testbench for the push button preset and reset controller.
// Assumes shortened counts: a 200 cycle mode window and a 20 to 40 cycle press span.
`timescale 1ns/1ps
`default_nettype none
module bprc_ctrl_tb;
   // ****************************************************************
   // Signals and table.
   // ****************************************************************
   localparam longint unsigned MINC = 20;
   localparam longint unsigned MAXC = 40;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic button = 1'b0;
   logic [3:0] sw_hi = 4'h0;
   logic [3:0] sw_lo = 4'h0;
   logic preset_wr = 1'b0;
   logic [31:0] preset_wdata = 32'h00000000;
   logic [1:0] stored_cfg_method = bprc_pkg::CFG_STATIC;
   logic [31:0] stored_ip = 32'h0A000005;
   logic factory_reset, preset_load, ip_from_switch, led_red, led_green;
   logic [31:0] preset_pos, ip_addr, pos_seen;
   logic [1:0] cfg_method;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   int n_fr, n_pl, red_lo, grn_lo, red_hi, grn_hi;
   typedef struct {logic [3:0] hi; logic [3:0] lo; logic [31:0] ip; logic sel; logic [1:0] meth;} bprc_row_t;
   bprc_row_t rows [5] = '{'{4'h4, 4'h2, 32'hC0A80142, 1'b1, 2'h0}, '{4'hF, 4'hF, 32'hC0A801FF, 1'b1, 2'h0},
      '{4'h1, 4'h0, 32'hC0A80110, 1'b1, 2'h0}, '{4'h0, 4'h1, 32'hC0A80101, 1'b1, 2'h0},
      '{4'h0, 4'h0, 32'h0A000005, 1'b0, 2'h0}};

   bprc_ctrl #(.MODE_CYC(200), .MIN_CYC(MINC), .MAX_CYC(MAXC), .BLINK_CYC(4)) i_dut (.clk(clk), .nrst(nrst),
      .button(button), .sw_hi(sw_hi), .sw_lo(sw_lo), .preset_wr(preset_wr), .preset_wdata(preset_wdata),
      .stored_cfg_method(stored_cfg_method), .stored_ip(stored_ip), .factory_reset(factory_reset),
      .preset_load(preset_load), .preset_pos(preset_pos), .ip_addr(ip_addr), .cfg_method(cfg_method),
      .ip_from_switch(ip_from_switch), .led_red(led_red), .led_green(led_green));

   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({31'h0, got}, {31'h0, exp}, what);
   endtask : chk_bit

   task automatic finish_test();
      $display("Counts: errors %0d, checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // Holds the button for n cycles, tallies the LED phases and the action pulses after release.
   task automatic press(input int n);
      {n_fr, n_pl, red_lo, grn_lo, red_hi, grn_hi} = '0;
      pos_seen = 32'hFFFFFFFF;
      button = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk) #1;
         if (i < MINC - 3)
         begin
            red_lo += int'(led_red === 1'b1);
            grn_lo += int'(led_green !== 1'b0);
         end
         if (i > MINC + 2 && i < MAXC - 3)
         begin
            red_hi += int'(led_red !== 1'b0);
            grn_hi += int'(led_green === 1'b1);
         end
      end
      button = 1'b0;
      repeat (4)
      begin
         @(posedge clk) #1;
         n_fr += int'(factory_reset !== 1'b0);
         n_pl += int'(preset_load !== 1'b0);
         if (preset_load === 1'b1)
            pos_seen = preset_pos;
      end
   endtask : press

   // Checks the pulse counts of the last press.
   task automatic chk_act(input int fr, input int pl);
      chk_word(32'(n_fr), 32'(fr), "factory reset pulses");
      chk_word(32'(n_pl), 32'(pl), "preset pulses");
   endtask : chk_act

   // ****************************************************************
   // Clock and timeout.
   // ****************************************************************
   // Makes the 250 MHz clock.
   initial
   begin
      forever #2 clk = ~clk;
   end

   // Cuts a hung run short well after the planned sequence.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         $display("mismatch at %0t: run did not finish", $time);
         finish_test();
      end
   end

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   // Reset, switch table, then presses inside and outside the power-on window.
   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      chk_bit(factory_reset, 1'b0, "factory pulse in reset");
      chk_bit(preset_load, 1'b0, "preset pulse in reset");
      chk_word(preset_pos, 32'h00000000, "position in reset");
      chk_word({30'h0, cfg_method}, {30'h0, bprc_pkg::CFG_DHCP}, "method in reset");
      nrst = 1'b1;
      foreach (rows[k])
      begin
         sw_hi = rows[k].hi;
         sw_lo = rows[k].lo;
         repeat (3) @(posedge clk);
         #1;
         chk_word(ip_addr, rows[k].ip, "address");
         chk_bit(ip_from_switch, rows[k].sel, "switch select");
         chk_word({30'h0, cfg_method}, {30'h0, rows[k].meth}, "method");
      end
      press(10);
      chk_act(0, 0);
      press(30);
      chk_act(1, 0);
      chk_bit(red_lo > 0 && grn_lo == 0, 1'b1, "red blink before minimum");
      chk_bit(grn_hi > 0 && red_hi == 0, 1'b1, "green blink in valid span");
      chk_word(ip_addr, 32'h00000000, "address after factory reset");
      chk_word({30'h0, cfg_method}, {30'h0, bprc_pkg::CFG_DHCP}, "method after factory reset");
      while (cyc < 260)
         @(posedge clk);
      #1;
      press(30);
      chk_act(0, 1);
      chk_word(pos_seen, 32'h00000000, "default preset");
      preset_wr = 1'b1;
      preset_wdata = 32'h12345678;
      @(posedge clk) #1;
      preset_wr = 1'b0;
      press(30);
      chk_word(pos_seen, 32'h12345678, "stored preset");
      preset_wr = 1'b1;
      preset_wdata = 32'h00000010;
      @(posedge clk) #1;
      preset_wr = 1'b0;
      press(30);
      chk_word(pos_seen, 32'h00000010, "absolute preset");
      chk_word(preset_pos, 32'h00000010, "position holds");
      press(50);
      chk_act(0, 0);
      // End points of the valid span: n high cycles leave n-1 counted cycles.
      press(20);
      chk_act(0, 0);
      press(21);
      chk_act(0, 1);
      press(41);
      chk_act(0, 1);
      press(42);
      chk_act(0, 0);
      finish_test();
   end
endmodule : bprc_ctrl_tb
`default_nettype wire

// >>> verilog/bprc_ctrl.sv
// Push button preset/reset controller with rotary switch address.
// Assumes a debounced synchronous button and static switch inputs.
`timescale 1ns/1ps
`default_nettype none
module bprc_ctrl #(
   parameter longint unsigned MODE_CYC = bprc_pkg::MODE_WINDOW_CYC,
   parameter longint unsigned MIN_CYC = bprc_pkg::PRESS_MIN_CYC,
   parameter longint unsigned MAX_CYC = bprc_pkg::PRESS_MAX_CYC,
   parameter longint unsigned BLINK_CYC = bprc_pkg::BLINK_HALF_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Button and rotary switches.
   input wire logic button,
   input wire logic [3:0] sw_hi,
   input wire logic [3:0] sw_lo,
   // Preset value storage, written by configuration.
   input wire logic preset_wr,
   input wire logic [31:0] preset_wdata,
   // Stored address configuration when switches are zero.
   input wire logic [1:0] stored_cfg_method,
   input wire logic [31:0] stored_ip,
   // Actions.
   output logic factory_reset,
   output logic preset_load,
   output logic [31:0] preset_pos,
   // Address.
   output logic [31:0] ip_addr,
   output logic [1:0] cfg_method,
   output logic ip_from_switch,
   // LEDs.
   output logic led_red,
   output logic led_green
);
   // ****************************************************************
   // Press timing.
   // ****************************************************************
   bprc_press_if pr ();

   bprc_press_timer #(.MODE_CYC(MODE_CYC), .MIN_CYC(MIN_CYC), .MAX_CYC(MAX_CYC)) u_tmr (
      .clk(clk),
      .nrst(nrst),
      .button(button),
      .pr(pr)
   );

   // ****************************************************************
   // Preset storage and actions.
   // ****************************************************************
   logic [31:0] preset_val_q;
   logic [bprc_pkg::CNT_W-1:0] blink_q;
   logic phase_q;
   logic [7:0] octet;
   logic cfg_dirty_q;
   logic [bprc_pkg::CNT_W-1:0] press_len_q;

   // Stored preset value; a factory reset puts it back to zero.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         preset_val_q <= bprc_pkg::PRESET_RST;
      else if (pr.valid_done && pr.in_window)
         preset_val_q <= bprc_pkg::PRESET_RST;
      else if (preset_wr)
         preset_val_q <= preset_wdata;
   end

   // Mode sampled at the valid release selects reset or preset.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         factory_reset <= 1'b0;
         preset_load <= 1'b0;
         preset_pos <= '0;
      end
      else
      begin
         factory_reset <= pr.valid_done && pr.in_window;
         preset_load <= pr.valid_done && !pr.in_window;
         if (pr.valid_done && !pr.in_window)
            preset_pos <= preset_val_q;
      end
   end

   // Stored network settings are ignored once a factory reset happened.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cfg_dirty_q <= 1'b1;
      else if (pr.valid_done && pr.in_window)
         cfg_dirty_q <= 1'b0;
   end

   // ****************************************************************
   // Address selection.
   // ****************************************************************
   // Switch one is the upper digit of the last octet.
   assign octet = {sw_hi, sw_lo};

   // Switch address wins unless both digits are zero.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ip_addr <= '0;
         cfg_method <= bprc_pkg::CFG_DHCP;
         ip_from_switch <= 1'b0;
      end
      else if (octet != 8'h00)
      begin
         ip_addr <= {bprc_pkg::NET_PREFIX, octet};
         cfg_method <= bprc_pkg::CFG_STATIC;
         ip_from_switch <= 1'b1;
      end
      else
      begin
         ip_addr <= cfg_dirty_q ? stored_ip : 32'h00000000;
         cfg_method <= cfg_dirty_q ? stored_cfg_method : bprc_pkg::CFG_DHCP;
         ip_from_switch <= 1'b0;
      end
   end

   // ****************************************************************
   // LED blinking.
   // ****************************************************************
   // Blink phase counter runs only while the button is held.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         blink_q <= '0;
         phase_q <= 1'b0;
      end
      else if (!button)
      begin
         blink_q <= '0;
         phase_q <= 1'b0;
      end
      else if (blink_q >= bprc_pkg::CNT_W'(BLINK_CYC - 1))
      begin
         blink_q <= '0;
         phase_q <= !phase_q;
      end
      else
         blink_q <= blink_q + 1'b1;
   end

   // Red while held outside the valid span, green once release would be valid.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         led_red <= 1'b0;
         led_green <= 1'b0;
      end
      else
      begin
         led_red <= button && !pr.held && !phase_q;
         led_green <= button && pr.held && !phase_q;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   sequence s_valid_early;
      pr.valid_done && pr.in_window;
   endsequence

   sequence s_valid_late;
      pr.valid_done && !pr.in_window;
   endsequence

   // Independent count of the current press, used only by the checks below.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         press_len_q <= '0;
      else if (!button)
         press_len_q <= '0;
      else if (press_len_q != '1)
         press_len_q <= press_len_q + 1'b1;
   end

   // A release after N high cycles leaves the timer with N-1 counted cycles.
   sequence s_rel_short;
      !button && (press_len_q != '0) && (press_len_q <= bprc_pkg::CNT_W'(MIN_CYC));
   endsequence

   sequence s_rel_long;
      !button && (press_len_q > bprc_pkg::CNT_W'(MAX_CYC + 1));
   endsequence

   sequence s_rel_ok;
      !button && (press_len_q > bprc_pkg::CNT_W'(MIN_CYC)) && (press_len_q <= bprc_pkg::CNT_W'(MAX_CYC + 1));
   endsequence

   a_short_none: assert property (@(posedge clk) disable iff (!nrst)
      s_rel_short |=> !factory_reset && !preset_load)
      else $error("Short press produced an action.");
   a_long_none: assert property (@(posedge clk) disable iff (!nrst)
      s_rel_long |=> !factory_reset && !preset_load)
      else $error("Overlong press produced an action.");
   a_valid_act: assert property (@(posedge clk) disable iff (!nrst)
      s_rel_ok |=> factory_reset || preset_load)
      else $error("Valid press produced no action.");

   a_reset_early: assert property (@(posedge clk) disable iff (!nrst) s_valid_early |=> factory_reset && !preset_load)
      else $error("Early press did not reset.");
   a_reset_net: assert property (@(posedge clk) disable iff (!nrst) s_valid_early ##1 1'b1 |=> !cfg_dirty_q)
      else $error("Reset kept network settings.");
   a_preset_late: assert property (@(posedge clk) disable iff (!nrst) s_valid_late |=> preset_load && !factory_reset)
      else $error("Late press did not preset.");
   a_preset_abs: assert property (@(posedge clk) disable iff (!nrst) s_valid_late |=> preset_pos == $past(preset_val_q))
      else $error("Preset position wrong.");
   a_led_color: assert property (@(posedge clk) disable iff (!nrst) !(led_red && led_green))
      else $error("Both LEDs lit.");
   a_led_idle: assert property (@(posedge clk) disable iff (!nrst) !button ##1 !button |-> !led_red && !led_green)
      else $error("LED lit while released.");
   a_ip_switch: assert property (@(posedge clk) disable iff (!nrst)
      (octet != 8'h00) |=> ip_addr == {bprc_pkg::NET_PREFIX, {4'h0, $past(sw_hi)} * 8'h10 + {4'h0, $past(sw_lo)}})
      else $error("Switch address wrong.");
   a_ip_zero: assert property (@(posedge clk) disable iff (!nrst) (octet == 8'h00) |=> !ip_from_switch)
      else $error("Zero switch used.");
   a_no_both: assert property (@(posedge clk) disable iff (!nrst) !(factory_reset && preset_load))
      else $error("Both actions fired.");
endmodule : bprc_ctrl
`default_nettype wire

// >>> verilog/bprc_pkg.sv
// Package for the push button preset and reset controller.
// Assumes a 250 MHz system clock; all counts are derived from it.
`default_nettype none
package bprc_pkg;
   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned MODE_WINDOW_S = 60;
   localparam int unsigned PRESS_MIN_S = 3;
   localparam int unsigned PRESS_MAX_S = 5;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam longint unsigned CYC_PER_S = 64'(CLK_MHZ) * 64'hF4240;
   localparam longint unsigned MODE_WINDOW_CYC = CYC_PER_S * MODE_WINDOW_S;
   localparam longint unsigned PRESS_MIN_CYC = CYC_PER_S * PRESS_MIN_S;
   localparam longint unsigned PRESS_MAX_CYC = CYC_PER_S * PRESS_MAX_S;
   localparam longint unsigned BLINK_HALF_CYC = 64'(CLK_MHZ) * 64'h3E8 * BLINK_HALF_MS;

   // ****************************************************************
   // Widths and values.
   // ****************************************************************
   localparam int unsigned CNT_W = 36;
   localparam int unsigned POS_W = 32;
   localparam logic [31:0] PRESET_RST = 32'h00000000;
   localparam logic [23:0] NET_PREFIX = 24'hC0A801;
   localparam logic [1:0] CFG_STATIC = 2'h0;
   localparam logic [1:0] CFG_DHCP = 2'h2;

   // Press tracker states.
   typedef enum logic [1:0] {BPRC_IDLE, BPRC_HELD, BPRC_OVER} bprc_state_t;
endpackage : bprc_pkg
`default_nettype wire

// >>> verilog/bprc_press_if.sv
// Interface carrying a finished press from the timer to the controller.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface bprc_press_if;
   logic valid_done;
   logic in_window;
   logic held;
   modport timer (output valid_done, output in_window, output held);
   modport ctrl (input valid_done, input in_window, input held);
endinterface : bprc_press_if
`default_nettype wire

// >>> verilog/bprc_press_timer.sv
// Press duration and power-on window timer.
// Assumes the button input is already debounced and synchronous.
`timescale 1ns/1ps
`default_nettype none
module bprc_press_timer #(
   parameter longint unsigned MODE_CYC = bprc_pkg::MODE_WINDOW_CYC,
   parameter longint unsigned MIN_CYC = bprc_pkg::PRESS_MIN_CYC,
   parameter longint unsigned MAX_CYC = bprc_pkg::PRESS_MAX_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Button level, high while pressed.
   input wire logic button,
   // Press results.
   bprc_press_if.timer pr
);
   logic [bprc_pkg::CNT_W-1:0] up_q;
   logic [bprc_pkg::CNT_W-1:0] hold_q;
   bprc_pkg::bprc_state_t st_q;
   logic ok_len;

   // Power-on counter saturates at the window end.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         up_q <= '0;
      else if (up_q < bprc_pkg::CNT_W'(MODE_CYC))
         up_q <= up_q + 1'b1;
   end

   // Press tracker; a press held beyond the maximum is dropped.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= bprc_pkg::BPRC_IDLE;
         hold_q <= '0;
      end
      else
      begin
         case (st_q)
            bprc_pkg::BPRC_IDLE:
            begin
               hold_q <= '0;
               if (button)
                  st_q <= bprc_pkg::BPRC_HELD;
            end
            bprc_pkg::BPRC_HELD:
            begin
               if (!button)
                  st_q <= bprc_pkg::BPRC_IDLE;
               else if (hold_q >= bprc_pkg::CNT_W'(MAX_CYC))
                  st_q <= bprc_pkg::BPRC_OVER;
               else
                  hold_q <= hold_q + 1'b1;
            end
            bprc_pkg::BPRC_OVER:
               if (!button)
                  st_q <= bprc_pkg::BPRC_IDLE;
            default:
               st_q <= bprc_pkg::BPRC_IDLE;
         endcase
      end
   end

   // Release is valid only inside the 3 to 5 second span.
   assign ok_len = (hold_q >= bprc_pkg::CNT_W'(MIN_CYC)) && (hold_q <= bprc_pkg::CNT_W'(MAX_CYC));
   assign pr.held = (st_q == bprc_pkg::BPRC_HELD) && ok_len;
   assign pr.valid_done = (st_q == bprc_pkg::BPRC_HELD) && !button && ok_len;
   assign pr.in_window = up_q < bprc_pkg::CNT_W'(MODE_CYC);

   a_short_drop: assert property (@(posedge clk) disable iff (!nrst)
      (hold_q < bprc_pkg::CNT_W'(MIN_CYC)) |-> !pr.valid_done)
      else $error("Short press accepted.");
endmodule : bprc_press_timer
`default_nettype wire
